// [logic/ccr_reg_bank.sv]
// Codec control register bank with page select and GPIO
//
// Notes on behaviour
// RQ1 - All registers eight bits, D7 most significant
// RQ2 - Page bit D0 selects page for accesses
// RQ3 - Host writes zeros to page bits D7-D1; bench class-D key sequence writes 8'h0d to the page register
// RQ4 - Host reads page bit back after write; bench key sequence page writes are not read back
// RQ5 - Reset bit D7 self-clearing; zero ignored
// RQ6 - Host leaves reset bits D6-D0 alone
// RQ7 - Host restores driver routing by writes
// RQ8 - ADC rate divider code 0 to 10
// RQ9 - DAC rate divider same encoding
// RQ10 - GPIO input level readable by register
// RQ11 - GPIO output drives host-chosen level
// RQ12 - GPIO selectable as clock or interrupt
// RQ13 - Four interrupt sources, single or ORed
// RQ14 - Status register shows interrupt cause
// RQ15 - Single pulse or train until status read
// RQ16 - Headset type readable in register 13
// RQ17 - Host writes class-D init sequence first
// RQ18 - Register 73 holds speaker enable, gain
// RQ19 - Host enables short detect for differential
// RQ20 - Soft reset restores all reset values
`timescale 1ns/100ps
module ccr_reg_bank
    import ccr_pkg::*;
(
    // Clock and reset
    input  wire logic            core_clk,
    input  wire logic            rst,
    // Register access from control bus slave
    input  wire ccr_pkg::ccr_req_s req,
    output logic [7:0]           rdata,
    // Status inputs from analog side
    input  wire ccr_pkg::ccr_irq_s irqEvents,
    input  wire logic [1:0]      headsetType,
    input  wire logic            intClk,
    // General purpose pin
    input  wire logic            gpioIn,
    output logic                 gpioOut,
    output logic                 gpioOe,
    // Controls to the datapath
    output logic                 activePage,
    output logic [3:0]           adcRateCode,
    output logic [3:0]           dacRateCode,
    output logic                 spkEnable,
    output logic [2:0]           spkGain
);
    import ccr_pkg::*;

    logic       page_reg, page_next;
    logic [7:0] rate_reg, rate_next;
    logic [7:0] gpio_reg, gpio_next;
    logic [7:0] route_reg, route_next;
    logic [7:0] spk_reg, spk_next;
    logic [7:0] key_reg, key_next;
    logic [3:0] stat_reg, stat_next;
    logic [7:0] rdata_next;
    logic       swRst_reg, swRst_next;
    logic       pinS1_reg, pinS2_reg, clkS1_reg, clkS2_reg;
    logic       pulse, trig, anyIrq;
    logic [3:0] evt, routed;

    // Address hit on page 0 only
    function automatic logic hit0(input logic [7:0] a, input logic p,
                                  input logic [7:0] ofs);
        return (a == ofs) && !p;
    endfunction

    // ==========================================================
    // Pin and clock synchronisers, input from outside domain
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pinS1_reg <= 1'b0;
            pinS2_reg <= 1'b0;
            clkS1_reg <= 1'b0;
            clkS2_reg <= 1'b0;
        end else begin
            pinS1_reg <= gpioIn;
            pinS2_reg <= pinS1_reg;
            clkS1_reg <= intClk;
            clkS2_reg <= clkS1_reg;
        end
    end

    // ==========================================================
    // Interrupt sources, routing mask selects which reach the pin
    assign evt    = {irqEvents.jack, irqEvents.button,
                     irqEvents.short_, irqEvents.agcNoise}; // RQ13
    assign routed = evt & route_reg[3:0];                   // RQ13
    assign trig   = |routed;
    assign anyIrq = |(stat_reg & route_reg[3:0]);

    // ==========================================================
    // Register write decode and status; events win over read-clear
    always_comb begin
        page_next  = page_reg;
        rate_next  = rate_reg;
        gpio_next  = gpio_reg;
        route_next = route_reg;
        spk_next   = spk_reg;
        key_next   = key_reg;
        swRst_next = 1'b0;
        stat_next  = stat_reg;
        if (req.rdEn && hit0(req.addr, page_reg, INT_STAT_OFS))
            stat_next = 4'h0;                                 // RQ15
        stat_next = stat_next | evt;                          // RQ14
        if (req.wrEn) begin
            if (req.addr == PAGE_SEL_OFS)
                page_next = req.wdata[PAGE_BIT];              // RQ2
            if (hit0(req.addr, page_reg, SOFT_RST_OFS))
                swRst_next = req.wdata[SOFT_RST_BIT];         // RQ5
            if (hit0(req.addr, page_reg, RATE_DIV_OFS))
                rate_next = req.wdata;                        // RQ8 RQ9
            if (hit0(req.addr, page_reg, GPIO_CTL_OFS))
                gpio_next = req.wdata;                        // RQ12
            if (hit0(req.addr, page_reg, INT_ROUTE_OFS))
                route_next = req.wdata;
            if (hit0(req.addr, page_reg, SPK_CTL_OFS))
                spk_next = req.wdata;                         // RQ18
            if (hit0(req.addr, page_reg, CLASSD_KEY_OFS))
                key_next = req.wdata;
        end
    end

    // Soft reset takes one cycle then clears itself
    always_ff @(posedge core_clk) begin
        if (rst || swRst_reg) begin                           // RQ20
            page_reg  <= PAGE_SEL_RST[PAGE_BIT];
            rate_reg  <= RATE_DIV_RST;
            gpio_reg  <= GPIO_CTL_RST;
            route_reg <= INT_ROUTE_RST;
            spk_reg   <= SPK_CTL_RST;
            key_reg   <= CLASSD_KEY_RST;
            stat_reg  <= 4'h0;
            swRst_reg <= 1'b0;                                // RQ5
        end else begin
            page_reg  <= page_next;
            rate_reg  <= rate_next;
            gpio_reg  <= gpio_next;
            route_reg <= route_next;
            spk_reg   <= spk_next;
            key_reg   <= key_next;
            stat_reg  <= stat_next;
            swRst_reg <= swRst_next;
        end
    end

    // ==========================================================
    // Read mux; write-only reset register reads zero
    always_comb begin
        rdata_next = 8'h00;
        if (req.addr == PAGE_SEL_OFS)
            rdata_next = {7'h00, page_reg};                   // RQ2
        else if (!page_reg) begin
            case (req.addr)
                RATE_DIV_OFS:   rdata_next = rate_reg;        // RQ8
                HSET_TYPE_OFS:  rdata_next = {headsetType, 6'h00}; // RQ16
                GPIO_CTL_OFS:   rdata_next = {gpio_reg[7:1], pinS2_reg};
                INT_STAT_OFS:   rdata_next = {4'h0, stat_reg}; // RQ14
                INT_ROUTE_OFS:  rdata_next = route_reg;
                SPK_CTL_OFS:    rdata_next = spk_reg;         // RQ18
                CLASSD_KEY_OFS: rdata_next = key_reg;
                default:        rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst)
            rdata <= 8'h00;
        else if (req.rdEn)
            rdata <= rdata_next;                              // RQ1 RQ10
    end

    // ==========================================================
    // Interrupt pulse generator
    ccr_pin_pulse u_pulse (
        .core_clk  (core_clk),
        .rst       (rst || swRst_reg),
        .trigger   (trig),
        .trainMode (gpio_reg[GPIO_PULSE_BIT]),
        .pending   (anyIrq),
        .pulseOut  (pulse)
    );

    // ==========================================================
    // GPIO pin function select; bits 7:6 mode, bit 3 output level
    always_comb begin
        gpioOe  = 1'b1;
        gpioOut = 1'b0;
        case (ccr_gpio_e'(gpio_reg[7:6]))
            GPIO_IN:  gpioOe  = 1'b0;                         // RQ10
            GPIO_OUT: gpioOut = gpio_reg[3];                  // RQ11
            GPIO_CLK: gpioOut = clkS2_reg;                    // RQ12
            GPIO_IRQ: gpioOut = pulse;                        // RQ12
            default:  gpioOe  = 1'b0;
        endcase
    end

    assign activePage  = page_reg;
    assign adcRateCode = rate_reg[ADC_RATE_LSB +: 4];
    assign dacRateCode = rate_reg[DAC_RATE_LSB +: 4];
    assign spkEnable   = spk_reg[SPK_EN_BIT];
    assign spkGain     = spk_reg[6:4];

    // ==========================================================
    // Checks
    a_page_write: assert property ( // RQ2
        @(posedge core_clk) disable iff (rst)
        req.wrEn && req.addr == PAGE_SEL_OFS && !swRst_reg
        |=> activePage == $past(req.wdata[0]))
        else $error("page bit not taken");
    a_swrst_clear: assert property ( // RQ20
        @(posedge core_clk) disable iff (rst)
        swRst_reg |=> !swRst_reg && !activePage && rate_reg == 8'h00)
        else $error("soft reset not applied");
    a_swrst_zero: assert property ( // RQ5
        @(posedge core_clk) disable iff (rst)
        req.wrEn && !req.wdata[7] |=> !swRst_reg)
        else $error("zero write triggered reset");
    a_rate_write: assert property ( // RQ8
        @(posedge core_clk) disable iff (rst)
        req.wrEn && req.addr == RATE_DIV_OFS && !activePage && !swRst_reg
        |=> {adcRateCode, dacRateCode} == $past(req.wdata))
        else $error("rate not stored");
    a_gpio_drive: assert property ( // RQ11
        @(posedge core_clk) disable iff (rst)
        gpio_reg[7:6] == 2'b01 |-> gpioOe && gpioOut == gpio_reg[3])
        else $error("gpio output wrong");
    a_gpio_input: assert property ( // RQ10
        @(posedge core_clk) disable iff (rst)
        gpio_reg[7:6] == 2'b00 |-> !gpioOe)
        else $error("gpio input driven");
    a_irq_sticky: assert property ( // RQ14
        @(posedge core_clk) disable iff (rst)
        |evt && !swRst_reg |=> (stat_reg & $past(evt)) == $past(evt))
        else $error("event lost");
    a_stat_read: assert property ( // RQ14
        @(posedge core_clk) disable iff (rst)
        req.rdEn && req.addr == INT_STAT_OFS && !activePage
        |=> rdata == {4'h0, $past(stat_reg)})
        else $error("status read wrong");
    c_page_one: cover property (@(posedge core_clk) activePage);
    c_sw_reset: cover property (@(posedge core_clk) swRst_reg);
    c_irq_pin:  cover property (@(posedge core_clk) pulse && gpioOe);
endmodule // ccr_reg_bank

// [logic/ccr_pkg.sv]
// Package for the codec control register bank
package ccr_pkg;
    // ==========================================================
    // Register offsets (page 0; page select decoded on both pages)
    localparam logic [7:0] PAGE_SEL_OFS   = 8'h00;
    localparam logic [7:0] SOFT_RST_OFS   = 8'h01;
    localparam logic [7:0] RATE_DIV_OFS   = 8'h02;
    localparam logic [7:0] CLASSD_KEY_OFS = 8'h08;
    localparam logic [7:0] HSET_TYPE_OFS  = 8'h0d;
    localparam logic [7:0] GPIO_CTL_OFS   = 8'h21;
    localparam logic [7:0] INT_STAT_OFS   = 8'h22;
    localparam logic [7:0] INT_ROUTE_OFS  = 8'h23;
    localparam logic [7:0] SPK_CTL_OFS    = 8'h49;
    // ==========================================================
    // Field positions
    localparam int PAGE_BIT      = 0;
    localparam int SOFT_RST_BIT  = 7;
    localparam int ADC_RATE_LSB  = 4;
    localparam int DAC_RATE_LSB  = 0;
    localparam int SPK_EN_BIT    = 7;
    localparam int GPIO_PULSE_BIT = 4;
    // ==========================================================
    // Reset values
    localparam logic [7:0] PAGE_SEL_RST  = 8'h00;
    localparam logic [7:0] RATE_DIV_RST  = 8'h00;
    localparam logic [7:0] GPIO_CTL_RST  = 8'h00;
    localparam logic [7:0] INT_ROUTE_RST = 8'h0f;
    localparam logic [7:0] SPK_CTL_RST   = 8'h00;
    localparam logic [7:0] CLASSD_KEY_RST = 8'h00;
    localparam logic [3:0] RATE_MAX_CODE = 4'ha;
    // ==========================================================
    // Timing: pulse width and train period of interrupt pin
    localparam int CLK_MHZ        = 50;
    localparam int PULSE_NS       = 2000;
    localparam int TRAIN_NS       = 20000;
    localparam int PULSE_CYC      = PULSE_NS * CLK_MHZ / 1000;
    localparam int TRAIN_CYC      = TRAIN_NS * CLK_MHZ / 1000;
    // ==========================================================
    // GPIO modes
    typedef enum logic [1:0] {
        GPIO_IN, GPIO_OUT, GPIO_CLK, GPIO_IRQ
    } ccr_gpio_e;
    // Register access request
    typedef struct packed {
        logic       wrEn;
        logic       rdEn;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ccr_req_s;
    // Interrupt sources: jack, button, short, agc noise
    typedef struct packed {
        logic jack;
        logic button;
        logic short_;
        logic agcNoise;
    } ccr_irq_s;
endpackage

// [logic/ccr_pin_pulse.sv]
// Interrupt pin pulse generator: single pulse or pulse train
`timescale 1ns/100ps
module ccr_pin_pulse
    import ccr_pkg::*;
#(
    parameter int PULSE_CYCLES = ccr_pkg::PULSE_CYC,
    parameter int TRAIN_CYCLES = ccr_pkg::TRAIN_CYC
) (
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic rst,
    // Control
    input  wire logic trigger,
    input  wire logic trainMode,
    input  wire logic pending,
    // Pin level
    output logic      pulseOut
);
    logic [15:0] cnt_reg, cnt_next;
    logic        act_reg, act_next;

    // ==========================================================
    // Next state: start on trigger, repeat while pending in train mode
    always_comb begin
        cnt_next = cnt_reg;
        act_next = act_reg;
        if (act_reg) begin
            if (cnt_reg == 16'(TRAIN_CYCLES - 1)) begin
                cnt_next = 16'h0000;
                act_next = trainMode && pending; // RQ15
            end else begin
                cnt_next = cnt_reg + 16'h0001;
            end
        end else if (trigger) begin
            act_next = 1'b1;
            cnt_next = 16'h0000;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            cnt_reg <= 16'h0000;
            act_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            act_reg <= act_next;
        end
    end

    // High for the first part of each period
    assign pulseOut = act_reg && (cnt_reg < 16'(PULSE_CYCLES)); // RQ15

    a_pulse_width: assert property ( // RQ15
        @(posedge core_clk) disable iff (rst)
        $rose(pulseOut) |-> pulseOut [*8])
        else $error("pulse shorter than minimum");
endmodule // ccr_pin_pulse

// [testbench/ccr_host_model.sv]
// Host processor model driving the register request port
`timescale 1ns/100ps
module ccr_host_model (
    // Clock
    input  wire logic         core_clk,
    // Request and answer
    input  wire logic [7:0]   rdata,
    output ccr_pkg::ccr_req_s req
);
    import ccr_pkg::*;
    // ==========================================================
    // Bus cycles
    initial req = '0;
    // Write strobe one cycle, then idle so strobes never merge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        req <= '{wrEn: 1'b1, rdEn: 1'b0, addr: a, wdata: d};
        @(posedge core_clk);
        req <= '0;
        #1;
    endtask
    // Read data is taken the cycle after the strobe edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        req <= '{wrEn: 1'b0, rdEn: 1'b1, addr: a, wdata: 8'h00};
        @(posedge core_clk);
        req <= '0;
        #1;
        d = rdata;
    endtask
    // Page change with confirming read back
    task automatic setPage(input logic p, output logic [7:0] d);
        wr(PAGE_SEL_OFS, {7'h00, p});
        rd(PAGE_SEL_OFS, d);
    endtask
endmodule // ccr_host_model

// [testbench/testbench.sv]
// Self-checking bench for the codec control register bank
`timescale 1ns/100ps
module testbench;
    import ccr_pkg::*;
    // ==========================================================
    // Signals
    logic       core_clk;
    logic       rst;
    ccr_req_s   req;
    logic [7:0] rdata;
    ccr_irq_s   irqEvents;
    logic [1:0] headsetType;
    logic       intClk;
    logic       gpioIn;
    logic       gpioOut;
    logic       gpioOe;
    logic       activePage;
    logic [3:0] adcRateCode;
    logic [3:0] dacRateCode;
    logic       spkEnable;
    logic [2:0] spkGain;
    logic [7:0] d;
    int         len;
    int         cycles;
    int         errCount;
    int         nChecks;
    localparam logic [15:0] KEY_SEQ [6] = '{16'h000d, 16'h0d0d,
        16'h085c, 16'h085d, 16'h085c, 16'h0000};
    // ==========================================================
    // Design and host
    ccr_reg_bank u_ccr_reg_bank (.core_clk(core_clk), .rst(rst),
        .req(req), .rdata(rdata), .irqEvents(irqEvents),
        .headsetType(headsetType), .intClk(intClk), .gpioIn(gpioIn),
        .gpioOut(gpioOut), .gpioOe(gpioOe), .activePage(activePage),
        .adcRateCode(adcRateCode), .dacRateCode(dacRateCode),
        .spkEnable(spkEnable), .spkGain(spkGain));
    ccr_host_model u_ccr_host_model (.core_clk(core_clk), .rdata(rdata),
        .req(req));
    // Clock and hang guard; the tests need well under 10000 cycles
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            errCount++;
            tallyAndFinish();
        end
    end
    // ==========================================================
    // Tasks
    task automatic tallyAndFinish();
        $display("checks %0d mismatches %0d", nChecks, errCount);
        if (errCount == 0 && nChecks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk8(input logic [7:0] exp, input logic [7:0] act);
        nChecks++;
        if (act !== exp) begin
            errCount++;
            $display("BAD t=%0t exp=%h got=%h", $time, exp, act);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        u_ccr_host_model.wr(a, v);
    endtask
    task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] v;
        u_ccr_host_model.rd(a, v);
        chk8(exp, v);
    endtask
    // One-cycle event pulse from the analog side
    task automatic fire(input logic [3:0] src);
        @(posedge core_clk);
        irqEvents <= ccr_irq_s'(src);
        @(posedge core_clk);
        irqEvents <= '0;
        #1;
    endtask
    // Width of the next pin pulse, zero if none within maxWait
    task automatic pinPulse(input int maxWait, output int n);
        int w;
        n = 0;
        w = 0;
        while (gpioOut !== 1'b1 && w < maxWait) begin
            @(posedge core_clk);
            #1;
            w++;
        end
        while (gpioOut === 1'b1 && n < 2000) begin
            @(posedge core_clk);
            #1;
            n++;
        end
    endtask
    // ==========================================================
    // Tests
    initial begin
        rst = 1'b1;
        irqEvents = '0;
        headsetType = 2'b00;
        intClk = 1'b0;
        gpioIn = 1'b0;
        cycles = 0;
        errCount = 0;
        nChecks = 0;
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        rdChk(PAGE_SEL_OFS, PAGE_SEL_RST);
        rdChk(RATE_DIV_OFS, RATE_DIV_RST);
        rdChk(INT_ROUTE_OFS, INT_ROUTE_RST);
        rdChk(SPK_CTL_OFS, SPK_CTL_RST);
        chk8(8'h00, {7'h00, gpioOe});
        $display("test reset values done");
        // Legal divider codes only; codes above ten are never sent
        for (int c = 0; c <= RATE_MAX_CODE; c++) begin
            wr(RATE_DIV_OFS, {4'(c), 4'(RATE_MAX_CODE - c)});
            chk8({4'(c), 4'(RATE_MAX_CODE - c)},
                 {adcRateCode, dacRateCode});
            rdChk(RATE_DIV_OFS, {4'(c), 4'(RATE_MAX_CODE - c)});
        end
        $display("test rate codes done");
        u_ccr_host_model.setPage(1'b1, d);
        chk8(8'h01, d);
        chk8(8'h01, {7'h00, activePage});
        wr(RATE_DIV_OFS, 8'h33);
        rdChk(RATE_DIV_OFS, 8'h00);
        u_ccr_host_model.setPage(1'b0, d);
        chk8(8'h00, d);
        rdChk(RATE_DIV_OFS, 8'ha0);
        $display("test page select done");
        foreach (KEY_SEQ[i]) begin
            wr(KEY_SEQ[i][15:8], KEY_SEQ[i][7:0]);
        end
        chk8(8'h00, {7'h00, activePage});
        // Key writes went to page 1, so page 0 copy is untouched
        rdChk(CLASSD_KEY_OFS, CLASSD_KEY_RST);
        wr(SPK_CTL_OFS, 8'hf0);
        chk8(8'hf0, {spkEnable, spkGain, 4'h0});
        @(posedge core_clk);
        headsetType <= 2'b10;
        u_ccr_host_model.rd(HSET_TYPE_OFS, d);
        chk8(8'h80, d & 8'hc0);
        $display("test speaker and headset done");
        wr(INT_ROUTE_OFS, 8'h03);
        wr(SOFT_RST_OFS, 8'h00);
        rdChk(INT_ROUTE_OFS, 8'h03);
        wr(SOFT_RST_OFS, 8'h80);
        repeat (2) @(posedge core_clk);
        rdChk(INT_ROUTE_OFS, INT_ROUTE_RST);
        rdChk(RATE_DIV_OFS, RATE_DIV_RST);
        chk8(8'h00, {spkEnable, spkGain, 4'h0});
        $display("test soft reset done");
        wr(GPIO_CTL_OFS, 8'h48);
        chk8(8'h03, {6'h00, gpioOe, gpioOut});
        wr(GPIO_CTL_OFS, 8'h40);
        chk8(8'h02, {6'h00, gpioOe, gpioOut});
        @(posedge core_clk);
        gpioIn <= 1'b1;
        wr(GPIO_CTL_OFS, 8'h00);
        repeat (3) @(posedge core_clk);
        rdChk(GPIO_CTL_OFS, 8'h01);
        chk8(8'h00, {7'h00, gpioOe});
        wr(GPIO_CTL_OFS, 8'h80);
        for (int i = 0; i < 2; i++) begin
            @(posedge core_clk);
            intClk <= ~i[0];
            repeat (4) @(posedge core_clk);
            #1;
            chk8({6'h00, 1'b1, ~i[0]}, {6'h00, gpioOe, gpioOut});
        end
        $display("test gpio modes done");
        // Routing restored by direct write, not left to soft reset
        wr(INT_ROUTE_OFS, 8'h08);
        wr(GPIO_CTL_OFS, 8'hc0);
        fire(4'h4);
        pinPulse(30, len);
        chk8(8'h00, 8'(len));
        fire(4'h8);
        pinPulse(30, len);
        chk8(8'd100, 8'(len));
        pinPulse(1200, len);
        chk8(8'h00, 8'(len));
        // Unrouted button event still shows in status
        u_ccr_host_model.rd(INT_STAT_OFS, d);
        chk8(8'h0c, d);
        // AGC noise source enabled along with the rest
        wr(INT_ROUTE_OFS, 8'h0f);
        wr(GPIO_CTL_OFS, 8'hd0);
        fire(4'h1);
        pinPulse(30, len);
        chk8(8'd100, 8'(len));
        pinPulse(1200, len);
        chk8(8'd100, 8'(len));
        u_ccr_host_model.rd(INT_STAT_OFS, d);
        chk8(8'h01, d);
        pinPulse(1200, len);
        chk8(8'h00, 8'(len));
        rdChk(INT_STAT_OFS, 8'h00);
        $display("test interrupt pin done");
        tallyAndFinish();
    end
endmodule // testbench
